// ### hdl/asrc_ctrl.sv
// How it works
// RULE1: write strobe stays high during reads
// RULE2: read lasts at least access time
// RULE3: lane data valid after byte select
// RULE4: data valid after output enable
// RULE5: memory drives late after chip select
// RULE6: bus released before output enable falls
// RULE7: lane drives late after byte select
// RULE8: release after chip select rises
// RULE9: release after output enable rises
// RULE10: lane release after byte select rises
// RULE11: old data held after address change
// RULE12: write select, pulse, address, cycle minimums
// RULE13: byte select and data setup, hold
// RULE14: memory releases when strobe falls
// RULE15: controller releases before strobe rises; the code releases one cycle after the strobe rises
// RULE16: late select keeps outputs high impedance
// RULE17: early deselect keeps outputs off
// RULE18: output enable high means no drive
// RULE19: never fight memory on data pins
// RULE20: deselect before retention, 5 ms recovery
// RULE21: read and write pin combinations
// RULE22: standby and output deselect states
// RULE23: whole clock cycles, rounded up
`timescale 1ns/1ps
module asrc_ctrl
	import asrc_pkg::*;
#(
	parameter int RECOVERY_COUNT = RECOVERY_CYCLES
) (
	input  wire logic                       clock,
	input  wire logic                       rst_b,
	input  wire logic                       req_valid,
	input  wire logic                       req_write,
	input  wire logic [asrc_pkg::ADDR_W-1:0] req_address,
	input  wire logic [asrc_pkg::DATA_W-1:0] req_wdata,
	input  wire logic [1:0]                 req_lane_n,
	input  wire logic                       retain_req,
	output logic                            req_ready,
	output logic                            rsp_valid,
	output logic [asrc_pkg::DATA_W-1:0]     rsp_rdata,
	output logic                            retained,
	output logic [asrc_pkg::ADDR_W-1:0]     word_address,
	output logic                            chip_select_n,
	output logic                            output_enable_n,
	output logic                            write_strobe_n,
	output logic                            low_byte_select_n,
	output logic                            high_byte_select_n,
	input  wire logic [asrc_pkg::DATA_W-1:0] shared_data_pins_in,
	output logic [asrc_pkg::DATA_W-1:0]     shared_data_pins_out,
	output logic                            shared_data_pins_oe_n
);
	import asrc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		asrc_state_type          state;
		logic [CNT_W-1:0]        count;
		logic [DATA_W-1:0]       din_meta;
		logic [DATA_W-1:0]       din_sync;
		logic                    retain_meta;
		logic                    retain_sync;
		logic                    ready;
		logic                    rvalid;
		logic [DATA_W-1:0]       rdata;
		logic                    retained;
		logic [ADDR_W-1:0]       addr;
		logic                    cs_n;
		logic                    oe_n;
		logic                    we_n;
		logic                    lb_n;
		logic                    ub_n;
		logic [DATA_W-1:0]       dout;
		logic                    dout_oe_n;
	} asrc_regs_type;

	asrc_regs_type s_reg;
	asrc_regs_type s_next;

	localparam asrc_regs_type RESET_REGS = '{
		state: ST_IDLE, count: '0, din_meta: '0, din_sync: '0, retain_meta: 1'b0,
		retain_sync: 1'b0, ready: 1'b0, rvalid: 1'b0, rdata: '0, retained: 1'b0,
		addr: '0, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, lb_n: 1'b1, ub_n: 1'b1,
		dout: '0, dout_oe_n: 1'b1};

	// pin data reaches din_sync two edges after it settles
	localparam int               PIN_SYNC_STAGES = 2;
	localparam logic [CNT_W-1:0] READ_LAST  = CNT_W'(READ_CYCLES + PIN_SYNC_STAGES - 1);
	localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(WRITE_PULSE_CYCLES - 1);
	localparam logic [CNT_W-1:0] TURN_LAST  = CNT_W'(TURN_CYCLES - 1);
	localparam logic [CNT_W-1:0] RECOV_LAST = CNT_W'(RECOVERY_COUNT - 1);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_next             = s_reg;
		s_next.din_meta    = shared_data_pins_in;
		s_next.din_sync    = s_reg.din_meta;
		s_next.retain_meta = retain_req;
		s_next.retain_sync = s_reg.retain_meta;
		s_next.rvalid      = 1'b0;
		s_next.count       = s_reg.count + CNT_W'(1);
		case (s_reg.state)
			ST_IDLE: begin
				// standby: everything deasserted, bus released
				s_next.cs_n      = 1'b1; // RULE22
				s_next.oe_n      = 1'b1;
				s_next.we_n      = 1'b1;
				s_next.lb_n      = 1'b1;
				s_next.ub_n      = 1'b1;
				s_next.dout_oe_n = 1'b1;
				s_next.ready     = 1'b1;
				s_next.count     = '0;
				if (s_reg.retain_sync) begin
					s_next.ready = 1'b0;
					s_next.state = ST_RETAIN; // RULE20
				end else if (req_valid && s_reg.ready) begin
					s_next.ready = 1'b0;
					s_next.addr  = req_address;
					s_next.cs_n  = 1'b0;
					s_next.lb_n  = req_lane_n[0];
					s_next.ub_n  = req_lane_n[1];
					if (req_write) begin
						// strobe and selects fall together, output enable stays high
						s_next.we_n      = 1'b0; // RULE12 RULE16 RULE18
						s_next.dout      = req_wdata; // RULE13
						s_next.dout_oe_n = 1'b0; // RULE19
						s_next.state     = ST_WRITE;
					end else begin
						s_next.oe_n  = 1'b0; // RULE6 RULE21
						s_next.state = ST_READ;
					end
				end
			end
			ST_READ: begin
				s_next.we_n = 1'b1; // RULE1
				if (s_reg.count == READ_LAST) begin // RULE2 RULE23
					s_next.rdata  = s_reg.din_sync;
					s_next.rvalid = 1'b1;
					s_next.cs_n   = 1'b1; // RULE8
					s_next.oe_n   = 1'b1; // RULE9
					s_next.lb_n   = 1'b1; // RULE10
					s_next.ub_n   = 1'b1;
					s_next.count  = '0;
					s_next.state  = ST_RTURN;
				end
			end
			ST_RTURN: begin
				// wait out the memory's release before the bus is reused
				if (s_reg.count == TURN_LAST) begin
					s_next.count = '0;
					s_next.state = ST_IDLE;
				end
			end
			ST_WRITE: begin
				if (s_reg.count == WRITE_LAST) begin // RULE12 RULE23
					// selects rise with the strobe; data held one more cycle
					s_next.we_n  = 1'b1; // RULE17
					s_next.cs_n  = 1'b1;
					s_next.lb_n  = 1'b1;
					s_next.ub_n  = 1'b1;
					s_next.count = '0;
					s_next.state = ST_WEND;
				end
			end
			ST_WEND: begin
				s_next.dout_oe_n = 1'b1; // RULE13 RULE15
				s_next.count     = '0;
				s_next.state     = ST_IDLE;
			end
			ST_RETAIN: begin
				s_next.cs_n     = 1'b1; // RULE20
				s_next.retained = 1'b1;
				s_next.count    = '0;
				if (!s_reg.retain_sync) begin
					s_next.state = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (s_reg.count == RECOV_LAST) begin // RULE20
					s_next.retained = 1'b0;
					s_next.count    = '0;
					s_next.state    = ST_IDLE;
				end
			end
			default: begin
				s_next = RESET_REGS;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s_reg <= RESET_REGS;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign req_ready             = s_reg.ready;
	assign rsp_valid             = s_reg.rvalid;
	assign rsp_rdata             = s_reg.rdata;
	assign retained              = s_reg.retained;
	assign word_address          = s_reg.addr;
	assign chip_select_n         = s_reg.cs_n;
	assign output_enable_n       = s_reg.oe_n;
	assign write_strobe_n        = s_reg.we_n;
	assign low_byte_select_n     = s_reg.lb_n;
	assign high_byte_select_n    = s_reg.ub_n;
	assign shared_data_pins_out  = s_reg.dout;
	assign shared_data_pins_oe_n = s_reg.dout_oe_n;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_READ_NO_STROBE: assert property (@(posedge clock) disable iff (!rst_b) // RULE1
		!output_enable_n |-> write_strobe_n) else $error("strobe low during read");
	AST_NO_FIGHT: assert property (@(posedge clock) disable iff (!rst_b) // RULE19
		!output_enable_n |-> shared_data_pins_oe_n) else $error("bus driven while output enabled");
	AST_READ_LEN: assert property (@(posedge clock) disable iff (!rst_b) // RULE2
		$fell(output_enable_n) |-> !output_enable_n [*3] ##1 output_enable_n) else $error("read length wrong");
	AST_WRITE_LEN: assert property (@(posedge clock) disable iff (!rst_b) // RULE12
		$fell(write_strobe_n) |-> !chip_select_n ##1 write_strobe_n) else $error("write pulse length wrong");
	AST_DATA_HOLD: assert property (@(posedge clock) disable iff (!rst_b) // RULE13
		$rose(write_strobe_n) |-> !shared_data_pins_oe_n && $stable(shared_data_pins_out)
		##1 shared_data_pins_oe_n) else $error("write data hold wrong");
	AST_SELECT_WITH_STROBE: assert property (@(posedge clock) disable iff (!rst_b) // RULE16
		$fell(write_strobe_n) |-> $fell(chip_select_n)) else $error("select not with strobe");
	AST_DESELECT_WITH_STROBE: assert property (@(posedge clock) disable iff (!rst_b) // RULE17
		$rose(write_strobe_n) |-> chip_select_n && low_byte_select_n && high_byte_select_n)
		else $error("select held after strobe");
	AST_OE_HIGH_IN_WRITE: assert property (@(posedge clock) disable iff (!rst_b) // RULE18
		!write_strobe_n |-> output_enable_n) else $error("output enable low during write");
	AST_RETAIN_DESELECT: assert property (@(posedge clock) disable iff (!rst_b) // RULE20
		retained |-> chip_select_n) else $error("selected during retention");
	AST_TURN: assert property (@(posedge clock) disable iff (!rst_b) // RULE6
		$rose(output_enable_n) |-> ##1 !req_ready) else $error("no turnaround after read");
endmodule : asrc_ctrl

// ### inc/asrc_pkg.sv
package asrc_pkg;
	// ----------------------------------------
	// memory geometry
	// ----------------------------------------
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;

	// ----------------------------------------
	// timing, ns and ms as printed, 10 MHz clock
	// ----------------------------------------
	localparam int CLK_PERIOD_NS          = 100;
	localparam int READ_CYCLE_MIN_NS      = 55;
	localparam int ADDRESS_TO_DATA_NS     = 55;
	localparam int WRITE_CYCLE_MIN_NS     = 55;
	localparam int WRITE_PULSE_MIN_NS     = 40;
	localparam int SELECT_TO_END_NS       = 45;
	localparam int DATA_SETUP_NS          = 25;
	localparam int RELEASE_MAX_NS         = 25;
	localparam int RECOVERY_MS            = 5;
	localparam int NS_PER_MS              = 1000000;

	function automatic int ceil_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ceil_cycles

	localparam int READ_CYCLES     = ceil_cycles((READ_CYCLE_MIN_NS > ADDRESS_TO_DATA_NS) ?
		READ_CYCLE_MIN_NS : ADDRESS_TO_DATA_NS);
	localparam int WRITE_PULSE_CYCLES = ceil_cycles((WRITE_PULSE_MIN_NS > SELECT_TO_END_NS) ?
		((WRITE_PULSE_MIN_NS > WRITE_CYCLE_MIN_NS) ? WRITE_PULSE_MIN_NS : WRITE_CYCLE_MIN_NS) :
		((SELECT_TO_END_NS > WRITE_CYCLE_MIN_NS) ? SELECT_TO_END_NS : WRITE_CYCLE_MIN_NS));
	localparam int TURN_CYCLES     = ceil_cycles(RELEASE_MAX_NS);
	localparam int RECOVERY_CYCLES = ceil_cycles(RECOVERY_MS * (NS_PER_MS / CLK_PERIOD_NS) * CLK_PERIOD_NS);
	localparam int CNT_W = 16;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_READ    = 3'h1,
		ST_RTURN   = 3'h3,
		ST_WRITE   = 3'h2,
		ST_WEND    = 3'h6,
		ST_RETAIN  = 3'h4,
		ST_RECOVER = 3'h5
	} asrc_state_type;
endpackage : asrc_pkg

// ### test/asrc_mem_model.sv
`timescale 1ns/1ps
module asrc_mem_model
	import asrc_pkg::*;
(
	input  wire logic [asrc_pkg::ADDR_W-1:0] word_address,
	input  wire logic                        chip_select_n,
	input  wire logic                        output_enable_n,
	input  wire logic                        write_strobe_n,
	input  wire logic                        low_byte_select_n,
	input  wire logic                        high_byte_select_n,
	input  wire logic                        host_drive_n,
	input  wire logic [asrc_pkg::DATA_W-1:0] host_data,
	output logic      [asrc_pkg::DATA_W-1:0] pins_level,
	output logic                             clash
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] last_drive = 16'hA5A5;
	logic [1:0]        lane_n;
	logic [1:0]        drive;
	logic [ADDR_W-1:0] read_address;

	// old word stays on the pins briefly after an address change
	assign #10 read_address = word_address;

	assign lane_n = {high_byte_select_n, low_byte_select_n};
	assign drive = (!chip_select_n && !output_enable_n && write_strobe_n) ? ~lane_n : 2'h0;
	assign clash = !host_drive_n && (drive != 2'h0);

	// released lanes show the inverse of the last driven byte
	always @* begin
		for (int i = 0; i < 2; i++) begin
			if (drive[i])
				last_drive[i*8 +: 8] = mem[read_address][i*8 +: 8];
			pins_level[i*8 +: 8] = !host_drive_n ? host_data[i*8 +: 8] :
				drive[i] ? mem[read_address][i*8 +: 8] : ~last_drive[i*8 +: 8];
		end
	end

	always @* begin
		if (!chip_select_n && !write_strobe_n) begin
			for (int i = 0; i < 2; i++)
				if (!lane_n[i])
					mem[word_address][i*8 +: 8] = pins_level[i*8 +: 8];
		end
	end
endmodule : asrc_mem_model

// ### test/test_async_sram_word_byte_access.sv
`timescale 1ns/1ps
module test_async_sram_word_byte_access;
	import asrc_pkg::*;
	localparam int RECOVERY = 8;
	logic              clock = 0, rst_b = 0, req_valid = 0, req_write = 0, retain_req = 0;
	logic [ADDR_W-1:0] req_address = '0, word_address;
	logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, pins_out, pins_level, q;
	logic [1:0]        req_lane_n = 2'h0;
	logic              req_ready, rsp_valid, retained, cs_n, oe_n, we_n, lb_n, hb_n, drive_n, clash;
	int                errors = 0, n_compared = 0, n;

	asrc_ctrl #(.RECOVERY_COUNT(RECOVERY)) uut (.clock(clock), .rst_b(rst_b), .req_valid(req_valid),
		.req_write(req_write), .req_address(req_address), .req_wdata(req_wdata), .req_lane_n(req_lane_n),
		.retain_req(retain_req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.retained(retained), .word_address(word_address), .chip_select_n(cs_n), .output_enable_n(oe_n),
		.write_strobe_n(we_n), .low_byte_select_n(lb_n), .high_byte_select_n(hb_n),
		.shared_data_pins_in(pins_level), .shared_data_pins_out(pins_out), .shared_data_pins_oe_n(drive_n));
	asrc_mem_model mem (.word_address(word_address), .chip_select_n(cs_n), .output_enable_n(oe_n),
		.write_strobe_n(we_n), .low_byte_select_n(lb_n), .high_byte_select_n(hb_n), .host_drive_n(drive_n),
		.host_data(pins_out), .pins_level(pins_level), .clash(clash));

	initial forever #50 clock = ~clock;

	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		n_compared++;
		if (seen !== expected) begin
			errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, expected);
		end
	endtask : check

	task automatic complete_run;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// ----------------------------------------
	// one request, held until taken
	// ----------------------------------------
	task automatic do_req(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [1:0] ln);
		logic took;
		took = 0;
		n = 0;
		req_valid = 1;
		req_write = wr;
		req_address = a;
		req_wdata = d;
		req_lane_n = ln;
		while (!took && n < 20) begin
			took = req_ready;
			@(posedge clock);
			#10;
			n++;
		end
		req_valid = 0;
		check(took, 1);
		check(req_ready, 0);
		if (!wr) begin
			check(rsp_valid, 0);
			n = 0;
			while (!rsp_valid && n < 10) begin
				@(posedge clock);
				#10;
				n++;
			end
			// access time plus two synchroniser stages on the pins
			check(n, READ_CYCLES + 2);
			check(rsp_valid, 1);
			q = rsp_rdata;
		end
		n = 0;
		while (!req_ready && n < 10) begin
			@(posedge clock);
			#10;
			n++;
		end
		check(req_ready, 1);
	endtask : do_req

	task automatic t_full;
		logic [ADDR_W-1:0] a [3] = '{18'h00000, 18'h3FFFF, 18'h12345};
		for (int i = 0; i < 3; i++)
			do_req(1, a[i], 16'h1F0E ^ {a[i][15:0]}, 2'h0);
		for (int i = 0; i < 3; i++) begin
			do_req(0, a[i], 16'h0, 2'h0);
			check(q, 16'h1F0E ^ {a[i][15:0]});
		end
		$display("full word test done");
	endtask : t_full

	task automatic t_lanes;
		do_req(1, 18'h00ABC, 16'hA5C3, 2'h0);
		do_req(1, 18'h00ABC, 16'h1E77, 2'h2);
		do_req(1, 18'h00ABC, 16'h0000, 2'h3);
		do_req(0, 18'h00ABC, 16'h0, 2'h1);
		check(q[15:8], 8'hA5);
		do_req(0, 18'h00ABC, 16'h0, 2'h2);
		check(q[7:0], 8'h77);
		do_req(0, 18'h00ABC, 16'h0, 2'h0);
		check(q, 16'hA577);
		$display("byte lane test done");
	endtask : t_lanes

	task automatic t_retain;
		retain_req = 1;
		n = 0;
		while (!retained && n < 8) begin
			@(posedge clock);
			#10;
			n++;
		end
		check(retained, 1);
		check({cs_n, req_ready}, 2'h2);
		retain_req = 0;
		n = 0;
		while (retained && n < 40) begin
			@(posedge clock);
			#10;
			check({cs_n, req_ready}, 2'h2);
			n++;
		end
		check(n >= RECOVERY && n < 40, 1);
		do_req(0, 18'h00ABC, 16'h0, 2'h0);
		check(q, 16'hA577);
		$display("retention test done");
	endtask : t_retain

	always @(negedge clock) begin
		if (clash)
			check(clash, 0);
		if (rst_b && !oe_n)
			check(we_n, 1);
	end

	initial begin
		repeat (3000) @(posedge clock);
		errors++;
		complete_run;
	end

	initial begin
		repeat (8) @(posedge clock);
		#10;
		check({cs_n, oe_n, we_n, lb_n, hb_n, drive_n, req_ready, rsp_valid}, 8'hFC);
		rst_b = 1;
		@(posedge clock);
		#10;
		$display("reset test done");
		t_full;
		t_lanes;
		t_retain;
		complete_run;
	end
endmodule : test_async_sram_word_byte_access
